// ### verilog/portc_change_regs.svh
// Register offsets, reset values and widths for the port change detector
`ifndef PORTC_CHANGE_REGS_SVH
`define PORTC_CHANGE_REGS_SVH
`define RISE_ENABLE_OFFSET  12'h000
`define FALL_ENABLE_OFFSET  12'h004
`define CHANGE_FLAG_OFFSET  12'h008
`define IRQ_STATUS_OFFSET   12'h00C
`define IRQ_MASK_OFFSET     12'h010
`define PORT_RESET_VALUE    8'h00
`define IRQ_RESET_VALUE     1'b0
`define ADDR_WIDTH          12
`define REG_WIDTH           8
`define WORD_ZERO           32'h0000_0000
`endif

// ### verilog/portc_change_pkg.sv
// Types for the port change detector
package portc_change_pkg;
   typedef enum logic [4:0]
   {
      SEL_RISE  = 5'b0_0001,
      SEL_FALL  = 5'b0_0010,
      SEL_FLAG  = 5'b0_0100,
      SEL_STAT  = 5'b0_1000,
      SEL_MASK  = 5'b1_0000
   } reg_sel_t;
endpackage

// ### verilog/portc_edge_change_detector.sv
// Per-pin edge change detector for an 8-bit port with an APB register slave
//
// Contract
// R1: A pin with its rising enable set raises a change event on a low-to-high transition.
// R2: A pin with its falling enable set raises a change event on a high-to-low transition.
// R3: An enabled edge sets that pin's change flag and the shared change-interrupt summary.
// R4: A rising edge counts only with the rising enable, a falling edge only with the falling enable.
// R5: With both enables zero a pin never sets its change flag.
// R6: Software clears a change flag by writing zero to it; zero means no change or cleared.
// R7: All enable and flag bits reset to zero on every reset.
// R8: The summary is set while any change flag is set, and pins are sampled on the clock.
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "portc_change_regs.svh"

module portc_edge_change_detector
   import portc_change_pkg::*;
#(
   parameter int PINS = 8
)
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [PINS-1:0]  portc_pin,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   input  wire logic [3:0]       pstrb,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   output logic                  change_interrupt_summary,
   output logic                  irq
);

   logic [PINS-1:0]  portc_rise_enable;
   logic [PINS-1:0]  portc_fall_enable;
   logic [PINS-1:0]  portc_change_flag;
   logic [PINS-1:0]  pin_prev;
   logic             irq_status;
   logic             irq_mask;
   logic [31:0]      read_data;
   logic [PINS-1:0]  next_rise_enable;
   logic [PINS-1:0]  next_fall_enable;
   logic [PINS-1:0]  next_change_flag;
   logic [PINS-1:0]  next_pin_prev;
   logic             next_irq_status;
   logic             next_irq_mask;
   logic [31:0]      next_read_data;
   logic [PINS-1:0]  edge_event;
   logic             access;
   logic             wr;
   logic             mapped;
   logic [5:0]       decoded;
   reg_sel_t         sel;

   // Decode a byte address to a register select, mapped flag in bit 5
   function automatic logic [5:0] decode(input logic [11:0] addr);
      case (addr)
         `RISE_ENABLE_OFFSET: decode = {1'b1, SEL_RISE};
         `FALL_ENABLE_OFFSET: decode = {1'b1, SEL_FALL};
         `CHANGE_FLAG_OFFSET: decode = {1'b1, SEL_FLAG};
         `IRQ_STATUS_OFFSET:  decode = {1'b1, SEL_STAT};
         `IRQ_MASK_OFFSET:    decode = {1'b1, SEL_MASK};
         default:             decode = {1'b0, SEL_RISE};
      endcase
   endfunction

   assign access  = psel & penable;
   assign wr      = access & pwrite & pstrb[0];
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;
   assign prdata  = read_data;
   assign decoded = decode(paddr);
   assign mapped  = decoded[5];
   assign sel     = reg_sel_t'(decoded[4:0]);

   // Edge qualification; previous pin level registered each clock
   assign edge_event = (portc_rise_enable & portc_pin & ~pin_prev)     // [R1] [R4] [R8]
                     | (portc_fall_enable & ~portc_pin & pin_prev);    // [R2] [R4] [R5]

   assign change_interrupt_summary = |portc_change_flag;                // [R3] [R8]
   assign irq = irq_status & irq_mask;

   // Enable registers: plain read-write words
   always_comb
   begin
      next_rise_enable = portc_rise_enable;
      next_fall_enable = portc_fall_enable;
      if (wr && mapped && sel == SEL_RISE)
      begin
         next_rise_enable = pwdata[PINS-1:0];
      end
      if (wr && mapped && sel == SEL_FALL)
      begin
         next_fall_enable = pwdata[PINS-1:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         portc_rise_enable <= `PORT_RESET_VALUE;   // [R7]
         portc_fall_enable <= `PORT_RESET_VALUE;   // [R7]
      end
      else
      begin
         portc_rise_enable <= next_rise_enable;
         portc_fall_enable <= next_fall_enable;
      end
   end

   // Change flags, sticky status and mask
   // Status is one sticky bit shared by all pins
   always_comb
   begin
      next_change_flag = portc_change_flag;
      next_irq_status  = irq_status;
      next_irq_mask    = irq_mask;
      if (wr && mapped)
      begin
         case (sel)
            // Writing zero clears a flag; writing one leaves it as is
            SEL_FLAG: next_change_flag = portc_change_flag & pwdata[PINS-1:0]; // [R6]
            SEL_STAT: next_irq_status  = irq_status & ~pwdata[0];
            SEL_MASK: next_irq_mask    = pwdata[0];
            default:  next_irq_mask    = irq_mask;
         endcase
      end
      // Hardware set wins over a same-cycle clear
      next_change_flag = next_change_flag | edge_event;                 // [R3]
      if (|edge_event)
      begin
         next_irq_status = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         portc_change_flag <= `PORT_RESET_VALUE;   // [R7]
         irq_status        <= `IRQ_RESET_VALUE;
         irq_mask          <= `IRQ_RESET_VALUE;
      end
      else
      begin
         portc_change_flag <= next_change_flag;
         irq_status        <= next_irq_status;
         irq_mask          <= next_irq_mask;
      end
   end

   // Read data is registered, so it shows one cycle after the access edge
   always_comb
   begin
      next_read_data = read_data;
      if (access && !pwrite && mapped)
      begin
         case (sel)
            SEL_RISE: next_read_data = {24'h00_0000, portc_rise_enable};
            SEL_FALL: next_read_data = {24'h00_0000, portc_fall_enable};
            SEL_FLAG: next_read_data = {24'h00_0000, portc_change_flag};
            SEL_STAT: next_read_data = {31'h0000_0000, irq_status};
            SEL_MASK: next_read_data = {31'h0000_0000, irq_mask};
            default:  next_read_data = `WORD_ZERO;
         endcase
      end
      else if (access)
      begin
         next_read_data = `WORD_ZERO;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         read_data <= `WORD_ZERO;
      end
      else
      begin
         read_data <= next_read_data;
      end
   end

   // Pin history for edge detection
   // It resets low, the idle pin level, so reset gives no false edge
   always_comb
   begin
      next_pin_prev = portc_pin;                                         // [R8]
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pin_prev <= `PORT_RESET_VALUE;
      end
      else
      begin
         pin_prev <= next_pin_prev;
      end
   end

   // Checks on the detector
   rise_sets_flag_a: assert property (@(posedge clk) disable iff (rst)   // [R1]
      (portc_rise_enable[0] && portc_pin[0] && !pin_prev[0]) |=> portc_change_flag[0])
      else $error("rising edge did not set flag");

   fall_sets_flag_a: assert property (@(posedge clk) disable iff (rst)   // [R2]
      (portc_fall_enable[0] && !portc_pin[0] && pin_prev[0]) |=> portc_change_flag[0])
      else $error("falling edge did not set flag");

   summary_follows_a: assert property (@(posedge clk) disable iff (rst)  // [R3]
      $rose(portc_change_flag[0]) |-> change_interrupt_summary)
      else $error("summary missing with flag set");

   only_enabled_edge_a: assert property (@(posedge clk) disable iff (rst) // [R4]
      (!portc_change_flag[0] && !(portc_rise_enable[0] && portc_pin[0] && !pin_prev[0])
       && !(portc_fall_enable[0] && !portc_pin[0] && pin_prev[0])) |=> !portc_change_flag[0])
      else $error("flag set without enabled edge");

   disabled_pin_quiet_a: assert property (@(posedge clk) disable iff (rst) // [R5]
      (!portc_rise_enable[0] && !portc_fall_enable[0] && !portc_change_flag[0])
      |=> !portc_change_flag[0])
      else $error("disabled pin set its flag");

   zero_write_clears_a: assert property (@(posedge clk) disable iff (rst) // [R6]
      (wr && sel == SEL_FLAG && mapped && !pwdata[0] && !edge_event[0]) |=> !portc_change_flag[0])
      else $error("zero write did not clear flag");

   reset_clears_a: assert property (@(posedge clk)                       // [R7]
      rst |=> (portc_rise_enable == 8'h00 && portc_fall_enable == 8'h00
               && portc_change_flag == 8'h00))
      else $error("reset left bits set");

   summary_empty_a: assert property (@(posedge clk) disable iff (rst)    // [R8]
      (portc_change_flag == 8'h00) |-> !change_interrupt_summary)
      else $error("summary set with no flags");

   irq_status_a: assert property (@(posedge clk) disable iff (rst)
      (|edge_event) |=> irq_status)
      else $error("event did not set status");

   // Every pin, not only pin 0
   for (genvar i = 0; i < PINS; i++)
   begin : pin_check
      pin_rise_a: assert property (@(posedge clk) disable iff (rst)   // [R1]
         (portc_rise_enable[i] && portc_pin[i] && !pin_prev[i]) |=> portc_change_flag[i])
         else $error("rising edge missed on a pin");

      pin_fall_a: assert property (@(posedge clk) disable iff (rst)   // [R2]
         (portc_fall_enable[i] && !portc_pin[i] && pin_prev[i]) |=> portc_change_flag[i])
         else $error("falling edge missed on a pin");

      pin_no_stray_a: assert property (@(posedge clk) disable iff (rst)   // [R4]
         $rose(portc_change_flag[i])
         |-> $past((portc_rise_enable[i] && portc_pin[i] && !pin_prev[i])
                   || (portc_fall_enable[i] && !portc_pin[i] && pin_prev[i])))
         else $error("flag rose without an enabled edge");

      pin_quiet_a: assert property (@(posedge clk) disable iff (rst)   // [R5]
         (!portc_rise_enable[i] && !portc_fall_enable[i] && !portc_change_flag[i])
         |=> !portc_change_flag[i])
         else $error("disabled pin set its flag");

      pin_clear_a: assert property (@(posedge clk) disable iff (rst)   // [R6]
         (wr && mapped && sel == SEL_FLAG && !pwdata[i] && !edge_event[i])
         |=> !portc_change_flag[i])
         else $error("zero write left a flag set");

      pin_sticky_a: assert property (@(posedge clk) disable iff (rst)   // [R3]
         (portc_change_flag[i] && !(wr && mapped && sel == SEL_FLAG && !pwdata[i]))
         |=> portc_change_flag[i])
         else $error("flag dropped without a clear");
   end

   pin_sample_a: assert property (@(posedge clk) disable iff (rst)   // [R8]
      1'b1 |=> pin_prev == $past(portc_pin))
      else $error("pin not sampled on the clock");

   rise_write_a: assert property (@(posedge clk) disable iff (rst)
      (wr && mapped && sel == SEL_RISE) |=> portc_rise_enable == $past(pwdata[PINS-1:0]))
      else $error("rise enable write lost");

   fall_write_a: assert property (@(posedge clk) disable iff (rst)
      (wr && mapped && sel == SEL_FALL) |=> portc_fall_enable == $past(pwdata[PINS-1:0]))
      else $error("fall enable write lost");

   mask_write_a: assert property (@(posedge clk) disable iff (rst)
      (wr && mapped && sel == SEL_MASK) |=> irq_mask == $past(pwdata[0]))
      else $error("mask write lost");

   status_clear_a: assert property (@(posedge clk) disable iff (rst)
      (wr && mapped && sel == SEL_STAT && pwdata[0] && !(|edge_event)) |=> !irq_status)
      else $error("status clear lost");

   read_flag_a: assert property (@(posedge clk) disable iff (rst)
      (access && !pwrite && mapped && sel == SEL_FLAG)
      |=> prdata[PINS-1:0] == $past(portc_change_flag))
      else $error("flag read returned wrong data");

   read_rise_a: assert property (@(posedge clk) disable iff (rst)
      (access && !pwrite && mapped && sel == SEL_RISE)
      |=> prdata[PINS-1:0] == $past(portc_rise_enable))
      else $error("rise enable read returned wrong data");

   read_fall_a: assert property (@(posedge clk) disable iff (rst)
      (access && !pwrite && mapped && sel == SEL_FALL)
      |=> prdata[PINS-1:0] == $past(portc_fall_enable))
      else $error("fall enable read returned wrong data");

   read_upper_a: assert property (@(posedge clk) disable iff (rst)
      (access && !pwrite) |=> prdata[31:PINS] == '0)
      else $error("upper read bits not zero");

   unmapped_read_a: assert property (@(posedge clk) disable iff (rst)
      (access && !pwrite && !mapped) |=> prdata == `WORD_ZERO)
      else $error("unmapped read returned data");

   status_sticky_a: assert property (@(posedge clk) disable iff (rst)
      (irq_status && !(wr && mapped && sel == SEL_STAT && pwdata[0])) |=> irq_status)
      else $error("status dropped without a clear");

   irq_masked_a: assert property (@(posedge clk) disable iff (rst)
      irq |-> (irq_mask && irq_status))
      else $error("irq raised while masked");

   summary_any_a: assert property (@(posedge clk) disable iff (rst)    // [R8]
      (|portc_change_flag) |-> change_interrupt_summary)
      else $error("flag set without summary");

   reset_outputs_a: assert property (@(posedge clk)                    // [R7]
      rst |=> (!irq && !change_interrupt_summary && prdata == `WORD_ZERO))
      else $error("outputs not cleared by reset");

   rise_event_c: cover property (@(posedge clk) disable iff (rst) |(edge_event & portc_pin));
   fall_event_c: cover property (@(posedge clk) disable iff (rst) |(edge_event & ~portc_pin));
   clear_flag_c: cover property (@(posedge clk) disable iff (rst)
      $fell(change_interrupt_summary));
   irq_raised_c: cover property (@(posedge clk) disable iff (rst) $rose(irq));
   set_wins_c: cover property (@(posedge clk) disable iff (rst)
      (wr && mapped && sel == SEL_FLAG && (|edge_event)));

endmodule

// ### verif/portc_pin_model.sv
// Model of the external drivers on the eight port pins
`timescale 1ns/1ps
module portc_pin_model
(
   input  wire logic       clk,
   input  wire logic [7:0] level_req,
   output logic      [7:0] portc_pin
);
   // Pins move just after a clock edge, as seen by the port
   always_ff @(posedge clk)
   begin
      portc_pin <= level_req;
   end
endmodule

// ### verif/tb_portc_edge_change_detector.sv
// Testbench for the port edge change detector
`timescale 1ns/1ps
`include "portc_change_regs.svh"
module tb_portc_edge_change_detector;
   logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, rd_done = 0;
   logic        summary, irq, pready, pslverr, last_err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic [7:0]  lvl = 0, pins, r, f, p0 = 0, p1, fl;
   logic        st = 0;
   logic [31:0] exq[$];
   int          n_mismatch = 0, checked = 0, cyc = 0, seed = 16;
   portc_pin_model pin_u (.clk(clk), .level_req(lvl), .portc_pin(pins));
   portc_edge_change_detector dut_u (.clk(clk), .rst(rst), .portc_pin(pins), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .change_interrupt_summary(summary), .irq(irq));
   initial forever #2 clk = ~clk;
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      last_err = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] exp);
      exq.push_back(exp);
      apb(0, a, 0);
   endtask
   // Read data lands one cycle after the completing edge
   always @(posedge clk)
   begin
      if (rd_done)
         check(prdata, exq.pop_front());
      rd_done <= psel & penable & ~pwrite & pready;
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         finish_test;
      end
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 0;
      rd(`RISE_ENABLE_OFFSET, 0);
      rd(`FALL_ENABLE_OFFSET, 0);
      rd(`CHANGE_FLAG_OFFSET, 0);
      $display("test reset done");
      repeat (8)
      begin
         r = $random(seed); f = $random(seed); p1 = $random(seed);
         apb(1, `RISE_ENABLE_OFFSET, {24'h0, r});
         apb(1, `FALL_ENABLE_OFFSET, {24'h0, f});
         apb(1, `CHANGE_FLAG_OFFSET, 0);
         @(posedge clk) lvl <= p1;
         repeat (3) @(posedge clk);
         fl = (~p0 & p1 & r) | (p0 & ~p1 & f);
         rd(`CHANGE_FLAG_OFFSET, {24'h0, fl});
         rd(`RISE_ENABLE_OFFSET, {24'h0, r});
         check(summary, |fl);
         st = st | (|fl);
         p0 = p1;
      end
      $display("test edges done");
      apb(1, `IRQ_MASK_OFFSET, 1);
      @(posedge clk);
      check(irq, st);
      apb(1, `IRQ_STATUS_OFFSET, 1);
      @(posedge clk);
      check(irq, 0);
      apb(1, `CHANGE_FLAG_OFFSET, 0);
      rd(`CHANGE_FLAG_OFFSET, 0);
      @(posedge clk);
      check(summary, 0);
      rd(12'h020, 0);
      check(last_err, 1);
      repeat (3) @(posedge clk);
      $display("test irq and clear done");
      finish_test;
   end
endmodule
